// ---- include/lvme_map_cfg.svh ----
// Purpose: Offsets, field positions and reset values for the outbound map decoders
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Summary list follows
// Summary of operation
// - Segment 1 word holds end address high half, start low half, writable.
// - Segments 2 to 4 repeat that pair at successive words, reset cleared.
// - Segment 4 alone has translation address high, translation select low.
// - Set select bit drives upper VME address from translation bit, else local.
// - Segments span 64 KB steps, one step up to the full 4 GB.
// - One attribute byte per segment: D16, write post, six-bit modifier.
// - A hit presents that segment's modifier code on the VME master cycle.
// - Write post set ends local write early, else waits for VME write.
// - D16 bit set gives 16-bit transfers, clear gives 32-bit.
// - Group field bits 31-24, reset zero, compared with VME A15-A8.
// - Board field bits 23-20, reset all ones, compared with VME A7-A4.
// - Board value all ones disables global block decoder, 0-14 enable it.
// - A16 address group,F,odd 1-7 selects location monitors 0-3 instead.
// - Enable bits 19-16, one per segment, cleared at reset.
`ifndef LVME_MAP_CFG_SVH
`define LVME_MAP_CFG_SVH
`define SEG1_ADDR_OFS    12'h014
`define SEG2_ADDR_OFS    12'h018
`define SEG3_ADDR_OFS    12'h01C
`define SEG4_ADDR_OFS    12'h020
`define SEG4_XLATE_OFS   12'h024
`define SEG_ATTR_OFS     12'h028
`define GLOBAL_CONTROL_STATUS_BLOCK_CTRL_OFS    12'h02C
`define HIT_STATUS_OFS   12'h030
`define ATTR_D16_BIT     7
`define ATTR_WP_BIT      6
`define GROUP_LSB        24
`define BOARD_LSB        20
`define ENABLE_LSB       16
`define GROUP_RESET      8'h00
`define BOARD_RESET      4'hF
`define BOARD_OFF        4'hF
`define MON_NIBBLE       4'hF
`endif

// ---- include/lvme_map_pkg.sv ----
// Purpose: Types shared by the outbound map decoder files
// Assumes: Nothing beyond the cfg header
// Notes:   Cycle phases of the outbound master
package lvme_map_pkg;
  typedef enum logic [1:0] {
    OB_IDLE = 2'b00,
    OB_VME  = 2'b01,
    OB_DONE = 2'b11
  } ob_state_t;
  typedef logic [15:0] seg_addr_t;
  typedef logic [7:0]  seg_attr_t;
endpackage : lvme_map_pkg

// ---- hdl/seg_window.sv ----
// Purpose: One outbound segment range compare
// Assumes: Bounds in 64 KB units
// Notes:   Combinational
`include "lvme_map_cfg.svh"
module seg_window
  import lvme_map_pkg::*;
(
  input  wire seg_addr_t start_addr,
  input  wire seg_addr_t end_addr,
  input  wire logic      enable,
  input  wire seg_addr_t local_hi,
  output logic           hit
);
  // Inclusive bounds, so start == end is one 64 KB step
  assign hit = enable && (local_hi >= start_addr) && (local_hi <= end_addr);
endmodule : seg_window

// ---- hdl/global_control_status_block_slave_decode.sv ----
// Purpose: Inbound decode of the global control/status block on A16
// Assumes: VME address sampled by the parent
// Notes:   Monitor slots win over the register block
`include "lvme_map_cfg.svh"
module global_control_status_block_slave_decode (
  input  wire logic [7:0]  group_addr,
  input  wire logic [3:0]  board_addr,
  input  wire logic [15:0] vme_addr,
  input  wire logic        a16_cycle,
  output logic             block_hit,
  output logic [3:0]       monitor_hit
);
  logic grp_match;
  logic mon_slot;
  assign grp_match = a16_cycle && (vme_addr[15:8] == group_addr);
  assign mon_slot  = grp_match && (vme_addr[7:4] == `MON_NIBBLE)
                     && vme_addr[0] && !vme_addr[3];
  always_comb begin
    monitor_hit = 4'h0;
    if (mon_slot) begin
      monitor_hit[vme_addr[2:1]] = 1'b1;
    end
  end
  assign block_hit = grp_match && !mon_slot && (board_addr != `BOARD_OFF)
                     && (vme_addr[7:4] == board_addr);
endmodule : global_control_status_block_slave_decode

// ---- hdl/local_to_vme_map_decoders.sv ----
// Purpose: Outbound map decoder registers, segment hit and VME master cycle control
// Assumes: Local and VME bus inputs arrive asynchronously; APB on core_clk
// Notes:   One local request at a time; VME handshake is level req/done
`include "lvme_map_cfg.svh"
module local_to_vme_map_decoders
  import lvme_map_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        local_req,
  input  wire logic        local_write,
  input  wire logic [31:0] local_addr,
  output logic             local_ack,
  output logic             local_miss,
  output logic             vme_req,
  output logic             vme_write,
  output logic      [31:0] vme_addr_out,
  output logic      [5:0]  vme_am,
  output logic             vme_d16,
  input  wire logic        vme_done,
  input  wire logic [15:0] vme_addr_in,
  input  wire logic        vme_a16_cycle,
  output logic             global_control_status_block,
  output logic             location_monitor_0,
  output logic             location_monitor_1,
  output logic             location_monitor_2,
  output logic             location_monitor_3
);
  seg_addr_t   seg_start [4];
  seg_addr_t   seg_end   [4];
  seg_attr_t   seg_attr  [4];
  seg_addr_t   xlate_addr;
  seg_addr_t   xlate_sel;
  logic [7:0]  group_addr;
  logic [3:0]  board_addr;
  logic [3:0]  seg_enable;
  logic        segment1_enable;
  logic        segment2_enable;
  logic        segment3_enable;
  logic        segment4_enable;
  logic [3:0]  seg_hit;
  logic [1:0]  hit_idx;
  logic        any_hit;
  logic [3:0]  last_hit;
  logic        last_miss;
  ob_state_t   ob_state;
  logic        posted;
  logic        apb_wr;
  logic        apb_rd;
  logic [31:0] next_prdata;
  logic        addr_ok;
  // Two-flop synchronisers for pins
  logic        req_s1, req_s2;
  logic        done_s1, done_s2;
  logic        a16_s1, a16_s2;
  logic [15:0] vaddr_s1, vaddr_s2;
  logic [31:0] laddr_s1, laddr_s2;
  logic        lwr_s1, lwr_s2;
  logic [3:0]  mon_hit;
  logic        blk_hit;

  assign segment1_enable = seg_enable[0];
  assign segment2_enable = seg_enable[1];
  assign segment3_enable = seg_enable[2];
  assign segment4_enable = seg_enable[3];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      done_s1  <= 1'b0;
      done_s2  <= 1'b0;
      a16_s1   <= 1'b0;
      a16_s2   <= 1'b0;
      vaddr_s1 <= 16'h0000;
      vaddr_s2 <= 16'h0000;
      laddr_s1 <= 32'h0000_0000;
      laddr_s2 <= 32'h0000_0000;
      lwr_s1   <= 1'b0;
      lwr_s2   <= 1'b0;
    end else begin
      req_s1   <= local_req;
      req_s2   <= req_s1;
      done_s1  <= vme_done;
      done_s2  <= done_s1;
      a16_s1   <= vme_a16_cycle;
      a16_s2   <= a16_s1;
      vaddr_s1 <= vme_addr_in;
      vaddr_s2 <= vaddr_s1;
      laddr_s1 <= local_addr;
      laddr_s2 <= laddr_s1;
      lwr_s1   <= local_write;
      lwr_s2   <= lwr_s1;
    end
  end

  // APB: zero-wait slave, unmapped offsets answer with pslverr
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite && addr_ok;
  assign apb_rd = psel && !penable && !pwrite;

  always_comb begin
    addr_ok     = 1'b1;
    next_prdata = 32'h0000_0000;
    if (paddr == `SEG1_ADDR_OFS) begin
      next_prdata = {seg_end[0], seg_start[0]};
    end else if (paddr == `SEG2_ADDR_OFS) begin
      next_prdata = {seg_end[1], seg_start[1]};
    end else if (paddr == `SEG3_ADDR_OFS) begin
      next_prdata = {seg_end[2], seg_start[2]};
    end else if (paddr == `SEG4_ADDR_OFS) begin
      next_prdata = {seg_end[3], seg_start[3]};
    end else if (paddr == `SEG4_XLATE_OFS) begin
      next_prdata = {xlate_addr, xlate_sel};
    end else if (paddr == `SEG_ATTR_OFS) begin
      next_prdata = {seg_attr[3], seg_attr[2], seg_attr[1], seg_attr[0]};
    end else if (paddr == `GLOBAL_CONTROL_STATUS_BLOCK_CTRL_OFS) begin
      next_prdata = {group_addr, board_addr, seg_enable, 16'h0000};
    end else if (paddr == `HIT_STATUS_OFS) begin
      next_prdata = {26'h0000000, last_miss, posted, last_hit};
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel && penable && !addr_ok;

  // Read data captured in setup so it comes from flops in access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        seg_start[i] <= 16'h0000;
        seg_end[i]   <= 16'h0000;
      end
    end else if (apb_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (paddr == `SEG1_ADDR_OFS + 12'(4 * i)) begin
          seg_end[i]   <= pwdata[31:16];
          seg_start[i] <= pwdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xlate_addr <= 16'h0000;
      xlate_sel  <= 16'h0000;
    end else if (apb_wr && paddr == `SEG4_XLATE_OFS) begin
      xlate_addr <= pwdata[31:16];
      xlate_sel  <= pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        seg_attr[i] <= 8'h00;
      end
    end else if (apb_wr && paddr == `SEG_ATTR_OFS) begin
      for (int i = 0; i < 4; i++) begin
        seg_attr[i] <= pwdata[8*i +: 8];
      end
    end
  end

  // Group/board may change any time; bus ownership is software's duty
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_addr <= `GROUP_RESET;
      board_addr <= `BOARD_RESET;
      seg_enable <= 4'h0;
    end else if (apb_wr && paddr == `GLOBAL_CONTROL_STATUS_BLOCK_CTRL_OFS) begin
      group_addr <= pwdata[`GROUP_LSB +: 8];
      board_addr <= pwdata[`BOARD_LSB +: 4];
      seg_enable <= pwdata[`ENABLE_LSB +: 4];
    end
  end

  // Segment compares
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_seg
      seg_window u_win (
        .start_addr (seg_start[g]),
        .end_addr   (seg_end[g]),
        .enable     (seg_enable[g]),
        .local_hi   (laddr_s2[31:16]),
        .hit        (seg_hit[g])
      );
    end
  endgenerate

  // Overlap is illegal; lowest segment wins if it happens
  always_comb begin
    hit_idx = 2'd0;
    if (seg_hit[0]) begin
      hit_idx = 2'd0;
    end else if (seg_hit[1]) begin
      hit_idx = 2'd1;
    end else if (seg_hit[2]) begin
      hit_idx = 2'd2;
    end else begin
      hit_idx = 2'd3;
    end
  end
  assign any_hit = |seg_hit;

  // Outbound cycle: local address held stable while local_req is high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ob_state     <= OB_IDLE;
      vme_req      <= 1'b0;
      vme_write    <= 1'b0;
      vme_addr_out <= 32'h0000_0000;
      vme_am       <= 6'h00;
      vme_d16      <= 1'b0;
      local_ack    <= 1'b0;
      local_miss   <= 1'b0;
      posted       <= 1'b0;
      last_hit     <= 4'h0;
      last_miss    <= 1'b0;
    end else begin
      case (ob_state)
        OB_IDLE: begin
          if (req_s2 && !local_ack && !local_miss) begin
            if (any_hit) begin
              vme_req   <= 1'b1;
              vme_write <= lwr_s2;
              vme_am    <= seg_attr[hit_idx][5:0];
              vme_d16   <= seg_attr[hit_idx][`ATTR_D16_BIT];
              if (hit_idx == 2'd3) begin
                vme_addr_out <= {(xlate_addr & xlate_sel)
                                 | (laddr_s2[31:16] & ~xlate_sel),
                                 laddr_s2[15:0]};
              end else begin
                vme_addr_out <= laddr_s2;
              end
              posted    <= lwr_s2 && seg_attr[hit_idx][`ATTR_WP_BIT];
              local_ack <= lwr_s2 && seg_attr[hit_idx][`ATTR_WP_BIT];
              last_hit  <= seg_hit;
              last_miss <= 1'b0;
              ob_state  <= OB_VME;
            end else begin
              local_miss <= 1'b1;
              last_miss  <= 1'b1;
              last_hit   <= 4'h0;
            end
          end else if (!req_s2) begin
            local_ack  <= 1'b0;
            local_miss <= 1'b0;
          end
        end
        OB_VME: begin
          if (!req_s2) begin
            local_ack <= 1'b0;
          end
          if (done_s2) begin
            vme_req  <= 1'b0;
            // Unposted cycles end locally only now
            local_ack <= !posted || req_s2;
            ob_state <= OB_DONE;
          end
        end
        OB_DONE: begin
          if (!done_s2) begin
            posted   <= 1'b0;
            ob_state <= OB_IDLE;
          end
        end
        default: begin
          ob_state <= OB_IDLE;
        end
      endcase
    end
  end

  // Inbound global block decode
  global_control_status_block_slave_decode u_global_control_status_block (
    .group_addr  (group_addr),
    .board_addr  (board_addr),
    .vme_addr    (vaddr_s2),
    .a16_cycle   (a16_s2),
    .block_hit   (blk_hit),
    .monitor_hit (mon_hit)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_control_status_block <= 1'b0;
      location_monitor_0          <= 1'b0;
      location_monitor_1          <= 1'b0;
      location_monitor_2          <= 1'b0;
      location_monitor_3          <= 1'b0;
    end else begin
      global_control_status_block <= blk_hit;
      location_monitor_0          <= mon_hit[0];
      location_monitor_1          <= mon_hit[1];
      location_monitor_2          <= mon_hit[2];
      location_monitor_3          <= mon_hit[3];
    end
  end

  a_board_off_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
    (board_addr == 4'hF) |=> !global_control_status_block)
    else $error("global block decoded while board field is all ones");

  a_enable_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> seg_enable == 4'h0)
    else $error("segment enables not cleared");

  a_hit_needs_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    seg_hit[0] |-> segment1_enable && laddr_s2[31:16] >= seg_start[0]
                   && laddr_s2[31:16] <= seg_end[0])
    else $error("segment one hit outside its window");

  a_am_from_attr: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ob_state == OB_IDLE && req_s2 && !local_ack && !local_miss && any_hit)
    |=> vme_req && vme_am == $past(seg_attr[hit_idx][5:0]))
    else $error("modifier code not taken from hit segment");

  a_d16_from_attr: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(vme_req) |-> vme_d16 == $past(seg_attr[hit_idx][7]))
    else $error("transfer width not from attribute");

  a_unposted_waits: assert property (@(posedge core_clk) disable iff (!rst_n)
    (vme_req && !posted) |-> !local_ack)
    else $error("unposted write acked before VME done");

  a_xlate_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($rose(vme_req) && $past(hit_idx) == 2'd3)
    |-> vme_addr_out[31:16] == (($past(xlate_addr) & $past(xlate_sel))
        | ($past(laddr_s2[31:16]) & ~$past(xlate_sel))))
    else $error("upper address translation wrong");

  a_monitor_slot: assert property (@(posedge core_clk) disable iff (!rst_n)
    (a16_s2 && vaddr_s2 == {group_addr, 8'hF3}) |=> location_monitor_1
      && !global_control_status_block)
    else $error("monitor slot not decoded");

  a_group_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> group_addr == 8'h00 && board_addr == 4'hF)
    else $error("group or board reset value wrong");
endmodule : local_to_vme_map_decoders

// ---- verif/vme_far_side.sv ----
// Purpose: Far-side VME responder for the outbound master cycle
// Assumes: Level req/done handshake on core_clk
// Notes:   Done drops only after the request falls, as the master expects
module vme_far_side (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       vme_req,
  input  wire logic [3:0] delay,
  output logic            vme_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;

  // Delay input lets the bench answer promptly or slowly
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vme_done <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (!vme_req) begin
      vme_done <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= delay) begin
      vme_done <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : vme_far_side

// ---- verif/local_to_vme_map_decoders_tb.sv ----
// Purpose: Self-checking bench for the outbound map decoders
// Assumes: pready may be held off; waits are bounded by the cycle ceiling
// Notes:   Expected values come from the bench's own copy of the settings
module local_to_vme_map_decoders_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, local_addr, vme_addr_out, attr_word;
  logic        local_req, local_write, local_ack, local_miss, vme_req, vme_write;
  logic        vme_d16, vme_done, vme_a16_cycle, gblk, lm0, lm1, lm2, lm3;
  logic [5:0]  vme_am;
  logic [15:0] vme_addr_in, xaddr, xsel;
  logic [15:0] seg_start [4];
  logic [15:0] seg_end [4];
  logic [3:0]  far_delay, en, brd;
  logic [7:0]  grp;
  logic [5:0]  am_tbl [6] = '{6'h09, 6'h0D, 6'h39, 6'h3D, 6'h29, 6'h2D};
  int          n_mismatch, check_count, cycles;

  local_to_vme_map_decoders dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .local_req(local_req), .local_write(local_write),
    .local_addr(local_addr), .local_ack(local_ack), .local_miss(local_miss),
    .vme_req(vme_req), .vme_write(vme_write), .vme_addr_out(vme_addr_out), .vme_am(vme_am),
    .vme_d16(vme_d16), .vme_done(vme_done), .vme_addr_in(vme_addr_in),
    .vme_a16_cycle(vme_a16_cycle), .global_control_status_block(gblk),
    .location_monitor_0(lm0), .location_monitor_1(lm1), .location_monitor_2(lm2),
    .location_monitor_3(lm3));
  vme_far_side far (.core_clk(core_clk), .rst_n(rst_n), .vme_req(vme_req),
    .delay(far_delay), .vme_done(vme_done));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 50000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  // Entered just after a rising edge; ends one idle edge later
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic load_cfg;
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 4; i++) apb(1'b1, 12'h014 + 12'(4 * i), {seg_end[i], seg_start[i]}, r, e);
    apb(1'b1, 12'h024, {xaddr, xsel}, r, e);
    apb(1'b1, 12'h028, attr_word, r, e);
    apb(1'b1, 12'h02C, {grp, brd, en, 16'h0000}, r, e);
  endtask : load_cfg

  function automatic int exp_seg(input logic [15:0] hi);
    for (int i = 0; i < 4; i++)
      if (en[i] && hi >= seg_start[i] && hi <= seg_end[i]) return i;
    return -1;
  endfunction : exp_seg

  task automatic local_xfer(input logic w, input logic [31:0] a);
    int          s, k;
    logic [7:0]  at;
    logic [15:0] up;
    logic        seen;
    logic [31:0] r;
    logic        e;
    s = exp_seg(a[31:16]);
    at = (s < 0) ? 8'h00 : 8'(attr_word >> (8 * s));
    up = (s == 3) ? ((xaddr & xsel) | (a[31:16] & ~xsel)) : a[31:16];
    local_req <= 1'b1; local_write <= w; local_addr <= a;
    k = 0;
    do begin @(posedge core_clk); k++; end while (vme_req !== 1'b1 && local_miss !== 1'b1 && k < 20);
    compare(local_miss, s < 0);
    compare(vme_req, s >= 0);
    if (s >= 0) begin
      compare(vme_addr_out, {up, a[15:0]});
      compare(vme_am, at[5:0]);
      compare(vme_d16, at[7]);
      compare(vme_write, w);
      compare(local_ack, w & at[6]);
      seen = 1'b0;
      k = 0;
      while (local_ack !== 1'b1 && k < 40) begin
        @(posedge core_clk);
        k++;
        if (vme_done === 1'b1) seen = 1'b1;
      end
      compare(local_ack, 1'b1);
      if (!(w & at[6])) compare(seen, 1'b1);
    end
    local_req <= 1'b0;
    k = 0;
    do begin @(posedge core_clk); k++; end
    while ((local_ack | local_miss | vme_req | vme_done) !== 1'b0 && k < 40);
    // Posted flag may linger while the done handshake winds down
    apb(1'b0, 12'h030, 32'h0, r, e);
    compare(r & 32'hFFFF_FFEF, {26'h0000000, s < 0, 1'b0, (s < 0) ? 4'h0 : 4'(1 << s)});
  endtask : local_xfer

  task automatic in_chk(input logic [15:0] a, input logic a16);
    logic [3:0] m;
    logic       b;
    for (int n = 0; n < 4; n++)
      m[n] = a16 && a[15:8] == grp && a[7:4] == 4'hF && a[3:0] == 4'(2 * n + 1);
    b = a16 && a[15:8] == grp && a[7:4] == brd && brd != 4'hF && m == 4'h0;
    vme_addr_in <= a; vme_a16_cycle <= a16;
    repeat (4) @(posedge core_clk);
    compare(gblk, b);
    compare({lm3, lm2, lm1, lm0}, m);
  endtask : in_chk

  initial begin
    logic [31:0] r, v;
    logic        e;
    logic [15:0] hi;
    static logic [15:0] corners [8] = '{16'h1000, 16'h1FFF, 16'h2000, 16'h2001, 16'h0FFF,
                                 16'hF000, 16'hFFFF, 16'hEFFF};
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; local_req = 1'b0; local_write = 1'b0; local_addr = 32'h0;
    vme_addr_in = 16'h0; vme_a16_cycle = 1'b0; far_delay = 4'h0;
    v = $urandom(64331);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'h014 + 12'(4 * i), 32'h0, r, e);
      compare(r, 32'h0);
      compare(e, 1'b0);
    end
    apb(1'b0, 12'h02C, 32'h0, r, e);
    compare(r, 32'h00F00000);
    apb(1'b1, 12'h040, 32'hFFFFFFFF, r, e);
    compare(e, 1'b1);
    apb(1'b0, 12'h040, 32'h0, r, e);
    compare({e, r}, {1'b1, 32'h0});
    grp = 8'h00; brd = 4'hF;
    in_chk(16'h00F0, 1'b1);
    repeat (3) for (int i = 0; i < 7; i++) begin
      v = (i == 6) ? ($urandom & 32'hFFFF0000) : $urandom;
      apb(1'b1, 12'h014 + 12'(4 * i), v, r, e);
      apb(1'b0, 12'h014 + 12'(4 * i), 32'h0, r, e);
      compare(r, v);
    end
    seg_start = '{16'h1000, 16'h2000, 16'h3000, 16'hF000};
    seg_end   = '{16'h1FFF, 16'h2000, 16'hEFFF, 16'hFFFF};
    xaddr = 16'($urandom); xsel = 16'($urandom); attr_word = 32'h0;
    grp = 8'($urandom); brd = 4'($urandom % 15); en = 4'h0;
    load_cfg();
    local_xfer(1'b1, 32'h10000000);
    en = 4'b1011;
    load_cfg();
    local_xfer(1'b0, 32'h30000000);
    en = 4'hF;
    for (int rnd = 0; rnd < 2; rnd++) begin
      for (int i = 0; i < 4; i++)
        attr_word[8 * i +: 8] = {1'(i) ^ 1'(rnd), 1'(i >> 1) ^ 1'(rnd), am_tbl[$urandom % 6]};
      load_cfg();
      for (int i = 0; i < 8; i++) local_xfer(1'(i + rnd), {corners[i], 16'($urandom)});
    end
    repeat (40) begin
      far_delay <= 4'($urandom % 6);
      v = $urandom % 5;
      hi = (v < 4) ? 16'(seg_start[v] + $urandom % (seg_end[v] - seg_start[v] + 1)) : 16'($urandom);
      local_xfer(1'($urandom), {hi, 16'($urandom)});
    end
    in_chk({grp, brd, 4'h3}, 1'b1);
    in_chk({grp, brd, 4'h3}, 1'b0);
    in_chk({grp ^ 8'h01, brd, 4'h0}, 1'b1);
    in_chk({grp, brd ^ 4'h1, 4'h0}, 1'b1);
    for (int i = 0; i < 10; i++) in_chk({grp, 4'hF, 4'(i)}, 1'b1);
    repeat (10) in_chk({($urandom % 2) ? grp : 8'($urandom), 8'($urandom)}, 1'b1);
    brd = 4'hF;
    load_cfg();
    in_chk({grp, 4'hF, 4'h0}, 1'b1);
    report_and_stop();
  end
endmodule : local_to_vme_map_decoders_tb
